// file: common/fce_pkg.sv
`default_nettype none
package fce_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_ACC = 8'h04;
  localparam logic [7:0] ADDR_DST = 8'h08;
  localparam logic [7:0] ADDR_SRC = 8'h0c;
  localparam logic [7:0] ADDR_FLAGS = 8'h10;
  localparam logic [7:0] ADDR_SI = 8'h14;
  localparam logic [7:0] ADDR_DI = 8'h18;
  localparam logic [7:0] ADDR_STAT = 8'h1c;
  // command register fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_WORD_POS = 3;
  // operation codes
  localparam logic [2:0] sign_extend_byte_op = 3'h0;
  localparam logic [2:0] clear_carry_op = 3'h1;
  localparam logic [2:0] clear_direction_op = 3'h2;
  localparam logic [2:0] clear_int_enable_op = 3'h3;
  localparam logic [2:0] invert_carry_op = 3'h4;
  localparam logic [2:0] compare_op = 3'h5;
  localparam logic [2:0] string_compare_op = 3'h6;
  localparam logic [2:0] soft_int_op = 3'h7;
  // flag word bit positions
  localparam int CARRY_FLAG_POS = 0;
  localparam int PARITY_FLAG_POS = 2;
  localparam int AUX_CARRY_FLAG_POS = 4;
  localparam int ZERO_FLAG_POS = 6;
  localparam int SIGN_FLAG_POS = 7;
  localparam int TRAP_FLAG_POS = 8;
  localparam int INT_ENABLE_FLAG_POS = 9;
  localparam int DIRECTION_FLAG_POS = 10;
  localparam int OVERFLOW_FLAG_POS = 11;
  localparam logic [15:0] FLAGS_RESET = 16'h0000;
  localparam logic [15:0] FLAGS_WR_MASK = 16'h0fd5;
  // status register bits
  localparam int STAT_BUSY_POS = 0;
  localparam int STAT_MASKABLE_POS = 1;
  localparam int STAT_NMI_POS = 2;
  // sign extension and string step constants
  localparam logic [7:0] SIGN_THRESHOLD = 8'h80;
  localparam logic [7:0] HIGH_ONES = 8'hff;
  localparam logic [7:0] HIGH_ZERO = 8'h00;
  localparam logic [15:0] BYTE_STEP = 16'h0001;
  localparam logic [15:0] WORD_STEP = 16'h0002;

  typedef enum logic [1:0] {
    FCE_IDLE,
    FCE_FETCH_DST,
    FCE_FETCH_SRC,
    FCE_EXEC
  } fce_state_t;

  // pin synchroniser with agreement filter
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic filt;
  } fce_sync_t;

  // memory read request
  typedef struct packed {
    logic req;
    logic word;
    logic [15:0] addr;
  } fce_mem_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    fce_state_t st;
    logic [2:0] op;
    logic word;
    logic [15:0] acc;
    logic [15:0] dst;
    logic [15:0] src;
    logic [15:0] flags;
    logic [15:0] si;
    logic [15:0] di;
    fce_mem_req_t mem;
    fce_sync_t mirq;
    fce_sync_t nmi;
    logic maskable_grant;
    logic nmi_take;
    logic soft_int_take;
  } fce_regs_t;
endpackage
`default_nettype wire

// file: design/fce_exec.sv
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none

// Contract
// - sign extend: high byte 00 below 80, else ff
// - unaffected flags keep their prior values
// - clear carry zeroes carry flag only
// - clear direction zeroes direction; strings then increment
// - clear interrupt zeroes interrupt enable only
// - maskable requests ignored while interrupt enable zero
// - nmi and soft interrupts always serviced
// - invert carry toggles carry flag only
// - compare subtracts without writing result back
// - compare sets six arithmetic flags from difference
// - string compare reads dest at di, source at si
// - string compare then steps both indexes by direction
module fce_exec (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // operand memory read port
  output logic mem_req,
  output logic mem_word,
  output logic [15:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  // interrupt pins and service requests
  input wire logic maskable_irq_input,
  input wire logic nmi_input,
  output logic maskable_grant,
  output logic nmi_take,
  output logic soft_int_take
);

  ////////////////////////////////////////////////////////////////////////////
  fce_pkg::fce_regs_t q_ff;
  fce_pkg::fce_regs_t nxt_q;
  logic wr;
  logic cmd_go;
  logic [2:0] op_in;
  logic [15:0] step;
  logic [15:0] rd_elem;
  logic [31:0] rd_mux;
  logic hit;

  // flags after destination minus source, other flags passed through
  function automatic logic [15:0] cmp_flags(input logic [15:0] d, input logic [15:0] s,
                                            input logic [15:0] f, input logic w);
    logic [16:0] rw;
    logic [8:0] rb;
    logic md;
    logic ms;
    logic mr;
    logic [15:0] o;
    rw = {1'b0, d} - {1'b0, s};
    rb = {1'b0, d[7:0]} - {1'b0, s[7:0]};
    md = w ? d[15] : d[7];
    ms = w ? s[15] : s[7];
    mr = w ? rw[15] : rb[7];
    o = f;
    o[fce_pkg::CARRY_FLAG_POS] = w ? rw[16] : rb[8];
    o[fce_pkg::AUX_CARRY_FLAG_POS] = d[3:0] < s[3:0];
    o[fce_pkg::ZERO_FLAG_POS] = w ? (rw[15:0] == 16'h0000) : (rb[7:0] == 8'h00);
    o[fce_pkg::SIGN_FLAG_POS] = mr;
    o[fce_pkg::OVERFLOW_FLAG_POS] = (md != ms) && (mr != md);
    o[fce_pkg::PARITY_FLAG_POS] = ~^rb[7:0];
    return o;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bus decode and read mux
  always_comb begin
    wr = psel && penable && q_ff.pready && pwrite;
    op_in = pwdata[fce_pkg::CMD_OP_LSB +: 3];
    cmd_go = wr && (paddr == fce_pkg::ADDR_CMD) && (q_ff.st == fce_pkg::FCE_IDLE);
    step = q_ff.word ? fce_pkg::WORD_STEP : fce_pkg::BYTE_STEP;
    rd_elem = q_ff.mem.word ? mem_rdata : {8'h00, mem_rdata[7:0]};
    hit = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      fce_pkg::ADDR_CMD: rd_mux = {28'h0000000, q_ff.word, q_ff.op};
      fce_pkg::ADDR_ACC: rd_mux = {16'h0000, q_ff.acc};
      fce_pkg::ADDR_DST: rd_mux = {16'h0000, q_ff.dst};
      fce_pkg::ADDR_SRC: rd_mux = {16'h0000, q_ff.src};
      fce_pkg::ADDR_FLAGS: rd_mux = {16'h0000, q_ff.flags};
      fce_pkg::ADDR_SI: rd_mux = {16'h0000, q_ff.si};
      fce_pkg::ADDR_DI: rd_mux = {16'h0000, q_ff.di};
      fce_pkg::ADDR_STAT: begin
        rd_mux[fce_pkg::STAT_BUSY_POS] = q_ff.st != fce_pkg::FCE_IDLE;
        rd_mux[fce_pkg::STAT_MASKABLE_POS] = q_ff.mirq.filt;
        rd_mux[fce_pkg::STAT_NMI_POS] = q_ff.nmi.filt;
      end
      default: hit = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    nxt_q = q_ff;
    // apb answer: one wait-free access phase
    if (psel && !penable) begin
      nxt_q.pready = 1'b1;
      nxt_q.pslverr = !hit;
      nxt_q.prdata = rd_mux;
    end else begin
      nxt_q.pready = 1'b0;
      nxt_q.pslverr = 1'b0;
    end
    // pin synchronisers, a change counts once stages two and three agree
    nxt_q.mirq.s1 = maskable_irq_input;
    nxt_q.mirq.s2 = q_ff.mirq.s1;
    nxt_q.mirq.s3 = q_ff.mirq.s2;
    if (q_ff.mirq.s2 == q_ff.mirq.s3) begin
      nxt_q.mirq.filt = q_ff.mirq.s3;
    end
    nxt_q.nmi.s1 = nmi_input;
    nxt_q.nmi.s2 = q_ff.nmi.s1;
    nxt_q.nmi.s3 = q_ff.nmi.s2;
    if (q_ff.nmi.s2 == q_ff.nmi.s3) begin
      nxt_q.nmi.filt = q_ff.nmi.s3;
    end
    // maskable request gated by interrupt enable
    nxt_q.maskable_grant = q_ff.mirq.filt && q_ff.flags[fce_pkg::INT_ENABLE_FLAG_POS];
    // nmi edge taken whatever the enable
    nxt_q.nmi_take = (q_ff.nmi.s2 == q_ff.nmi.s3) && q_ff.nmi.s3 && !q_ff.nmi.filt;
    nxt_q.soft_int_take = 1'b0;
    case (q_ff.st)
      fce_pkg::FCE_IDLE: begin
        if (cmd_go) begin
          nxt_q.op = op_in;
          nxt_q.word = pwdata[fce_pkg::CMD_WORD_POS];
          case (op_in)
            fce_pkg::sign_extend_byte_op: begin
              // flags untouched
              nxt_q.acc[15:8] = (q_ff.acc[7:0] < fce_pkg::SIGN_THRESHOLD) ?
                                fce_pkg::HIGH_ZERO : fce_pkg::HIGH_ONES;
            end
            fce_pkg::clear_carry_op: nxt_q.flags[fce_pkg::CARRY_FLAG_POS] = 1'b0;
            fce_pkg::clear_direction_op: begin
              nxt_q.flags[fce_pkg::DIRECTION_FLAG_POS] = 1'b0;
            end
            fce_pkg::clear_int_enable_op: begin
              nxt_q.flags[fce_pkg::INT_ENABLE_FLAG_POS] = 1'b0;
            end
            fce_pkg::invert_carry_op: begin
              nxt_q.flags[fce_pkg::CARRY_FLAG_POS] = !q_ff.flags[fce_pkg::CARRY_FLAG_POS];
            end
            fce_pkg::compare_op: begin
              // operands left as they were
              nxt_q.flags = cmp_flags(q_ff.dst, q_ff.src, q_ff.flags,
                                      pwdata[fce_pkg::CMD_WORD_POS]);
            end
            fce_pkg::string_compare_op: begin
              nxt_q.st = fce_pkg::FCE_FETCH_DST;
              nxt_q.mem.req = 1'b1;
              nxt_q.mem.word = pwdata[fce_pkg::CMD_WORD_POS];
              nxt_q.mem.addr = q_ff.di;
            end
            fce_pkg::soft_int_op: nxt_q.soft_int_take = 1'b1;
            default: nxt_q.op = q_ff.op;
          endcase
        end else if (wr) begin
          // operand and state writes, only while idle
          case (paddr)
            fce_pkg::ADDR_ACC: nxt_q.acc = pwdata[15:0];
            fce_pkg::ADDR_DST: nxt_q.dst = pwdata[15:0];
            fce_pkg::ADDR_SRC: nxt_q.src = pwdata[15:0];
            fce_pkg::ADDR_FLAGS: nxt_q.flags = pwdata[15:0] & fce_pkg::FLAGS_WR_MASK;
            fce_pkg::ADDR_SI: nxt_q.si = pwdata[15:0];
            fce_pkg::ADDR_DI: nxt_q.di = pwdata[15:0];
            default: nxt_q.acc = q_ff.acc;
          endcase
        end
      end
      fce_pkg::FCE_FETCH_DST: begin
        if (mem_ack) begin
          nxt_q.dst = rd_elem;
          nxt_q.mem.addr = q_ff.si;
          nxt_q.st = fce_pkg::FCE_FETCH_SRC;
        end
      end
      fce_pkg::FCE_FETCH_SRC: begin
        if (mem_ack) begin
          nxt_q.src = rd_elem;
          nxt_q.mem.req = 1'b0;
          nxt_q.st = fce_pkg::FCE_EXEC;
        end
      end
      fce_pkg::FCE_EXEC: begin
        // flags from elements, then indexes step by direction
        nxt_q.flags = cmp_flags(q_ff.dst, q_ff.src, q_ff.flags, q_ff.word);
        if (!q_ff.flags[fce_pkg::DIRECTION_FLAG_POS]) begin
          nxt_q.si = q_ff.si + step;
          nxt_q.di = q_ff.di + step;
        end else begin
          nxt_q.si = q_ff.si - step;
          nxt_q.di = q_ff.di - step;
        end
        nxt_q.st = fce_pkg::FCE_IDLE;
      end
      default: nxt_q.st = fce_pkg::FCE_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_ff <= '0;
      q_ff.flags <= fce_pkg::FLAGS_RESET;
      q_ff.st <= fce_pkg::FCE_IDLE;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // outputs straight from the state register
  assign prdata = q_ff.prdata;
  assign pready = q_ff.pready;
  assign pslverr = q_ff.pslverr;
  assign mem_req = q_ff.mem.req;
  assign mem_word = q_ff.mem.word;
  assign mem_addr = q_ff.mem.addr;
  assign maskable_grant = q_ff.maskable_grant;
  assign nmi_take = q_ff.nmi_take;
  assign soft_int_take = q_ff.soft_int_take;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_sign_ext;
    cmd_go && op_in == fce_pkg::sign_extend_byte_op |=>
      q_ff.acc[15:8] == ($past(q_ff.acc[7]) ? 8'hff : 8'h00) && $stable(q_ff.acc[7:0]);
  endproperty
  a_sign_ext: assert property (p_sign_ext) else $error("sign extension wrong");

  property p_sext_flags;
    cmd_go && op_in == fce_pkg::sign_extend_byte_op |=> $stable(q_ff.flags);
  endproperty
  a_sext_flags: assert property (p_sext_flags) else $error("flags moved on extend");

  property p_clc;
    cmd_go && op_in == fce_pkg::clear_carry_op |=>
      !q_ff.flags[0] && q_ff.flags[15:1] == $past(q_ff.flags[15:1]);
  endproperty
  a_clc: assert property (p_clc) else $error("clear carry wrong");

  property p_cld;
    cmd_go && op_in == fce_pkg::clear_direction_op |=>
      !q_ff.flags[10] && q_ff.flags[9:0] == $past(q_ff.flags[9:0]);
  endproperty
  a_cld: assert property (p_cld) else $error("clear direction wrong");

  property p_cli;
    cmd_go && op_in == fce_pkg::clear_int_enable_op |=>
      !q_ff.flags[9] && q_ff.flags[8:0] == $past(q_ff.flags[8:0]);
  endproperty
  a_cli: assert property (p_cli) else $error("clear interrupt wrong");

  property p_mask;
    !q_ff.flags[9] |=> !q_ff.maskable_grant;
  endproperty
  a_mask: assert property (p_mask) else $error("masked request granted");

  property p_nmi;
    $rose(q_ff.nmi.filt) |-> q_ff.nmi_take ##1 !q_ff.nmi_take;
  endproperty
  a_nmi: assert property (p_nmi) else $error("nmi not taken once");

  property p_cmc;
    cmd_go && op_in == fce_pkg::invert_carry_op |=>
      q_ff.flags[0] != $past(q_ff.flags[0]) && q_ff.flags[15:1] == $past(q_ff.flags[15:1]);
  endproperty
  a_cmc: assert property (p_cmc) else $error("invert carry wrong");

  property p_cmp_keep;
    cmd_go && op_in == fce_pkg::compare_op |=> $stable(q_ff.dst) && $stable(q_ff.src);
  endproperty
  a_cmp_keep: assert property (p_cmp_keep) else $error("compare wrote operand");

  property p_cmp_eq;
    cmd_go && op_in == fce_pkg::compare_op && q_ff.dst == q_ff.src |=>
      q_ff.flags[6] && !q_ff.flags[0] && !q_ff.flags[11];
  endproperty
  a_cmp_eq: assert property (p_cmp_eq) else $error("equal compare flags wrong");

  property p_str_addr;
    q_ff.st == fce_pkg::FCE_FETCH_DST |-> q_ff.mem.req && q_ff.mem.addr == q_ff.di;
  endproperty
  a_str_addr: assert property (p_str_addr) else $error("string fetch address wrong");

  property p_str_step;
    q_ff.st == fce_pkg::FCE_EXEC |=>
      q_ff.di == $past(q_ff.di) + ($past(q_ff.flags[10]) ? -$past(step) : $past(step))
      && q_ff.si - $past(q_ff.si) == q_ff.di - $past(q_ff.di);
  endproperty
  a_str_step: assert property (p_str_step) else $error("index step wrong");

  property p_step_size;
    q_ff.st == fce_pkg::FCE_EXEC && !q_ff.flags[10] |=>
      q_ff.si == $past(q_ff.si) + ($past(q_ff.word) ? 16'h0002 : 16'h0001);
  endproperty
  a_step_size: assert property (p_step_size) else $error("step size wrong");

  // source fetch follows the source index
  property p_str_src;
    q_ff.st == fce_pkg::FCE_FETCH_SRC |-> q_ff.mem.req && q_ff.mem.addr == q_ff.si;
  endproperty
  a_str_src: assert property (p_str_src) else $error("source fetch address wrong");

  // elements stay as fetched while the flags settle
  property p_str_keep;
    q_ff.st == fce_pkg::FCE_EXEC |=> $stable(q_ff.dst) && $stable(q_ff.src);
  endproperty
  a_str_keep: assert property (p_str_keep) else $error("string element modified");

  // an enabled request is passed on one cycle later
  property p_grant;
    q_ff.mirq.filt && q_ff.flags[fce_pkg::INT_ENABLE_FLAG_POS] |=> q_ff.maskable_grant;
  endproperty
  a_grant: assert property (p_grant) else $error("enabled request not granted");

  // software interrupt gives one pulse whatever the enable
  property p_soft_int;
    cmd_go && op_in == fce_pkg::soft_int_op |=> q_ff.soft_int_take ##1 !q_ff.soft_int_take;
  endproperty
  a_soft_int: assert property (p_soft_int) else $error("soft interrupt not taken once");

  c_string: cover property (cmd_go && op_in == fce_pkg::string_compare_op ##[3:20]
                            q_ff.st == fce_pkg::FCE_EXEC);
  c_compare: cover property (cmd_go && op_in == fce_pkg::compare_op);
  c_grant: cover property (q_ff.maskable_grant);
  c_nmi_masked: cover property (q_ff.nmi_take && !q_ff.flags[9]);

endmodule

`default_nettype wire

// file: dv/flag_and_compare_execution_tb.sv
`timescale 1ns/10ps
`default_nettype none
module flag_and_compare_execution_tb;
  logic pclk, presetn, psel, penable, pwrite, mem_ack, maskable_irq_input, nmi_input;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd_data;
  logic pready, pslverr, mem_req, mem_word, maskable_grant, nmi_take, soft_int_take, err;
  logic [15:0] mem_addr, mem_rdata;
  int fails = 0;
  int n_compared = 0;

  fce_exec dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_req(mem_req), .mem_word(mem_word), .mem_addr(mem_addr),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .maskable_irq_input(maskable_irq_input),
    .nmi_input(nmi_input), .maskable_grant(maskable_grant), .nmi_take(nmi_take),
    .soft_int_take(soft_int_take)
  );

  //////////////////////////////////////////////////////////////////////////////
  // clock generator
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // compare and count
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic print_verdict;
    if (fails == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // one apb transfer, entered right after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk("pready", 32'h1, 32'(pready));
    rd_data = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle edge so the next call never redrives psel in this time step
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rd_data);
  endtask

  // expected arithmetic flags of dst minus src
  function automatic logic [15:0] cmp_f(input logic [15:0] d, s, input logic w);
    logic [16:0] x;
    logic [15:0] f;
    f = 16'h0;
    x = w ? {1'b0, d} - {1'b0, s} : {9'h0, d[7:0]} - {9'h0, s[7:0]};
    f[fce_pkg::CARRY_FLAG_POS] = w ? x[16] : x[8];
    f[fce_pkg::SIGN_FLAG_POS] = w ? x[15] : x[7];
    f[fce_pkg::ZERO_FLAG_POS] = w ? (x[15:0] == 16'h0) : (x[7:0] == 8'h0);
    f[fce_pkg::OVERFLOW_FLAG_POS] = w ? (d[15] != s[15]) && (x[15] != d[15])
                                      : (d[7] != s[7]) && (x[7] != d[7]);
    f[fce_pkg::AUX_CARRY_FLAG_POS] = d[3:0] < s[3:0];
    f[fce_pkg::PARITY_FLAG_POS] = ~^x[7:0];
    return f;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic sc_sign_ext;
    wr(fce_pkg::ADDR_FLAGS, 32'h0000_0fd5);
    wr(fce_pkg::ADDR_ACC, 32'h0000_127f);
    wr(fce_pkg::ADDR_CMD, 32'(fce_pkg::sign_extend_byte_op));
    rd(fce_pkg::ADDR_ACC, 32'h0000_007f, "acc low below");
    wr(fce_pkg::ADDR_ACC, 32'h0000_0080);
    wr(fce_pkg::ADDR_CMD, 32'(fce_pkg::sign_extend_byte_op));
    rd(fce_pkg::ADDR_ACC, 32'h0000_ff80, "acc low at edge");
    rd(fce_pkg::ADDR_FLAGS, 32'h0000_0fd5, "flags kept");
  endtask

  task automatic sc_flag_ops;
    wr(fce_pkg::ADDR_FLAGS, 32'h0000_0fd5);
    wr(fce_pkg::ADDR_CMD, 32'(fce_pkg::clear_carry_op));
    rd(fce_pkg::ADDR_FLAGS, 32'h0000_0fd4, "clear carry");
    wr(fce_pkg::ADDR_CMD, 32'(fce_pkg::invert_carry_op));
    rd(fce_pkg::ADDR_FLAGS, 32'h0000_0fd5, "invert zero");
    wr(fce_pkg::ADDR_CMD, 32'(fce_pkg::invert_carry_op));
    rd(fce_pkg::ADDR_FLAGS, 32'h0000_0fd4, "invert one");
    wr(fce_pkg::ADDR_CMD, 32'(fce_pkg::clear_direction_op));
    rd(fce_pkg::ADDR_FLAGS, 32'h0000_0bd4, "clear direction");
    wr(fce_pkg::ADDR_CMD, 32'(fce_pkg::clear_int_enable_op));
    rd(fce_pkg::ADDR_FLAGS, 32'h0000_09d4, "clear int enable");
  endtask

  // register compares over a small table of operand pairs
  task automatic sc_compare;
    logic [15:0] dv[5] = '{16'h0005, 16'h8000, 16'h1234, 16'h0080, 16'hff10};
    logic [15:0] sv[5] = '{16'h0007, 16'h0001, 16'h1234, 16'h007f, 16'h0120};
    logic wv[5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
    for (int i = 0; i < 5; i++) begin
      wr(fce_pkg::ADDR_FLAGS, 32'h0);
      wr(fce_pkg::ADDR_DST, 32'(dv[i]));
      wr(fce_pkg::ADDR_SRC, 32'(sv[i]));
      wr(fce_pkg::ADDR_CMD, 32'({wv[i], fce_pkg::compare_op}));
      rd(fce_pkg::ADDR_FLAGS, 32'(cmp_f(dv[i], sv[i], wv[i])), "compare flags");
      rd(fce_pkg::ADDR_DST, 32'(dv[i]), "dst kept");
      rd(fce_pkg::ADDR_SRC, 32'(sv[i]), "src kept");
    end
  endtask

  // answer one element request after one idle cycle
  task automatic elem(input logic [15:0] a, input logic [15:0] d, input logic w);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (mem_req !== 1'b1 && n < 20);
    chk("element request", 32'h1, 32'(mem_req));
    chk("element address", 32'(a), 32'(mem_addr));
    chk("element width", 32'(w), 32'(mem_word));
    mem_ack <= 1'b1;
    mem_rdata <= d;
    @(posedge pclk);
    mem_ack <= 1'b0;
    mem_rdata <= ~d;
  endtask

  task automatic sc_string(input logic dir, input logic w, input logic [15:0] dv, sv);
    logic [15:0] st;
    st = w ? 16'h0002 : 16'h0001;
    wr(fce_pkg::ADDR_FLAGS, 32'({dir, 10'h0}));
    wr(fce_pkg::ADDR_SI, 32'h0000_0100);
    wr(fce_pkg::ADDR_DI, 32'h0000_0200);
    wr(fce_pkg::ADDR_CMD, 32'({w, fce_pkg::string_compare_op}));
    wr(fce_pkg::ADDR_DI, 32'h0000_0300);
    rd(fce_pkg::ADDR_STAT, 32'h0000_0001, "busy");
    elem(16'h0200, dv, w);
    elem(16'h0100, sv, w);
    repeat (2) @(posedge pclk);
    rd(fce_pkg::ADDR_SI, 32'(dir ? 16'h0100 - st : 16'h0100 + st), "src index");
    rd(fce_pkg::ADDR_DI, 32'(dir ? 16'h0200 - st : 16'h0200 + st), "dst index");
    rd(fce_pkg::ADDR_FLAGS, 32'(cmp_f(dv, sv, w) | {dir, 10'h0}), "string flags");
  endtask

  task automatic sc_irq;
    int n;
    maskable_irq_input <= 1'b1;
    repeat (8) @(posedge pclk);
    chk("grant masked", 32'h0, 32'(maskable_grant));
    wr(fce_pkg::ADDR_FLAGS, 32'h0000_0200);
    repeat (3) @(posedge pclk);
    chk("grant enabled", 32'h1, 32'(maskable_grant));
    wr(fce_pkg::ADDR_CMD, 32'(fce_pkg::clear_int_enable_op));
    repeat (3) @(posedge pclk);
    chk("grant after clear", 32'h0, 32'(maskable_grant));
    nmi_input <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (nmi_take !== 1'b1 && n < 12);
    chk("nmi taken", 32'h1, 32'(nmi_take));
    @(posedge pclk);
    chk("nmi pulse end", 32'h0, 32'(nmi_take));
    wr(fce_pkg::ADDR_CMD, 32'(fce_pkg::soft_int_op));
    n = 0;
    while (soft_int_take !== 1'b1 && n < 4) begin
      @(posedge pclk);
      n++;
    end
    chk("soft int taken", 32'h1, 32'(soft_int_take));
    maskable_irq_input <= 1'b0;
    nmi_input <= 1'b0;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    mem_ack = 1'b0;
    mem_rdata = 16'h0;
    maskable_irq_input = 1'b0;
    nmi_input = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(fce_pkg::ADDR_FLAGS, 32'h0, "flags reset");
    sc_sign_ext();
    sc_flag_ops();
    sc_compare();
    sc_string(1'b0, 1'b1, 16'h1234, 16'h1235);
    sc_string(1'b1, 1'b0, 16'haa90, 16'h5510);
    sc_irq();
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped error", 32'h1, 32'(err));
    chk("unmapped data", 32'h0, rd_data);
    print_verdict();
  end

  // watchdog cuts a hang short
  initial begin
    repeat (5000) @(posedge pclk);
    fails++;
    print_verdict();
  end
endmodule
`default_nettype wire
